// *** rtl/gmcr_pkg.sv ***
// Purpose: constants and types for the gauge mode and control register bank
// Assumes: byte-wide register port fed by the serial slave framing logic
// Notes:   table defaults hold state-of-charge codes and open-circuit-voltage codes
package gmcr_pkg;

	localparam int TAB_ENTRIES = 16;

	// register addresses
	localparam logic [7:0] ADDR_MODE     = 8'h00;
	localparam logic [7:0] ADDR_CTRL     = 8'h01;
	localparam logic [7:0] ADDR_OCV_BASE = 8'h30;
	localparam logic [7:0] ADDR_OCV_LAST = 8'h4F;
	localparam logic [7:0] ADDR_SOC_BASE = 8'h50;
	localparam logic [7:0] ADDR_SOC_LAST = 8'h5F;

	// operating mode bit positions
	localparam int MODE_VOLT_ONLY = 0;
	localparam int MODE_PULLUP    = 1;
	localparam int MODE_CD_FORCE  = 2;
	localparam int MODE_ALM_EN    = 3;
	localparam int MODE_OPERATE   = 4;
	localparam int MODE_FORCE_COUNTER_STATE  = 5;
	localparam int MODE_FORCE_VOLTAGE_STATE  = 6;

	// control and status bit positions
	localparam int CTRL_ALM_PIN   = 0;
	localparam int CTRL_CNT_CLR   = 1;
	localparam int CTRL_SRC_VOLT  = 2;
	localparam int CTRL_BAT_REM   = 3;
	localparam int CTRL_POR       = 4;
	localparam int CTRL_LOW_CHG   = 5;
	localparam int CTRL_LOW_VOLT  = 6;
	localparam int CTRL_UVLO      = 7;

	typedef struct packed {
		logic force_voltage_state;
		logic force_counter_state;
		logic gauge_operate;
		logic alarm_enable;
		logic charger_disable_force;
		logic detect_pullup_enable;
		logic voltage_only_select;
	} gmcr_mode_t;

	typedef struct packed {
		logic undervoltage_lockout_flag;
		logic low_voltage_flag;
		logic low_charge_flag;
		logic power_reset_flag;
		logic battery_removed_flag;
		logic charge_source_voltage;
		logic alarm_pin_drive;
	} gmcr_ctrl_t;

	typedef logic [TAB_ENTRIES-1:0][7:0]  gmcr_soc_tab_t;
	typedef logic [TAB_ENTRIES-1:0][15:0] gmcr_ocv_tab_t;

	localparam gmcr_mode_t MODE_RESET = '{
		force_voltage_state:   1'h0,
		force_counter_state:   1'h0,
		gauge_operate:         1'h0,
		alarm_enable:          1'h1,
		charger_disable_force: 1'h0,
		detect_pullup_enable:  1'h1,
		voltage_only_select:   1'h1
	};

	localparam gmcr_ctrl_t CTRL_RESET = '{
		undervoltage_lockout_flag: 1'h0,
		low_voltage_flag:          1'h0,
		low_charge_flag:           1'h0,
		power_reset_flag:          1'h1,
		battery_removed_flag:      1'h0,
		charge_source_voltage:     1'h0,
		alarm_pin_drive:           1'h1
	};

	// entry 15 first, entry 0 last
	localparam gmcr_soc_tab_t SOC_DEFAULT = {
		8'hC8, 8'hB4, 8'hA0, 8'h8C, 8'h82, 8'h78, 8'h64, 8'h50,
		8'h3C, 8'h32, 8'h28, 8'h1E, 8'h14, 8'h0C, 8'h06, 8'h00
	};

	localparam gmcr_ocv_tab_t OCV_DEFAULT = {
		16'h1DA9, 16'h1CF3, 16'h1C58, 16'h1BE8, 16'h1BB1, 16'h1B70, 16'h1B01, 16'h1AD5,
		16'h1AB6, 16'h1A9D, 16'h1A6D, 16'h1A3E, 16'h19FB, 16'h19B2, 16'h1926, 16'h1770
	};

endpackage

// *** rtl/gmcr_regs.sv ***
// Purpose: mode, control/status and charge/voltage table registers of a gas gauge
// Assumes: byte accesses arrive already deframed as address, data and strobes
// Notes:   a soft reset write restores the mode, control and table registers within the same edge
`timescale 1ns/1ps
`default_nettype none

// Contract
// R1: mode bit 0 picks mixed or voltage-only gauging, resets to 1.
// R2: mode bit 1 connects the detect-input pull-up, resets to 1.
// R3: mode bit 2 forces charger-disable output high, else internal logic drives it.
// R4: mode bit 3 enables the alarm function, resets enabled.
// R5: mode bit 4 selects operating; 0 means standby with frozen gauge.
// R6: writing mode bit 5 zeroes the relaxation counter, then self-clears.
// R7: writing mode bit 6 loads the relaxation counter maximum, then self-clears.
// R8: control bit 0 reads back the alarm pin level.
// R9: control bit 0 written 0 forces alarm low, 1 lets alarms drive.
// R10: control bit 1 written 1 clears the conversion counter, self-clearing.
// R11: control bit 2 reads 1 when charge comes from voltage mode.
// R12: control bit 3 set by removal; write 0 clears only with detect low.
// R13: control bit 4 reads 1 after a power-on reset, resets to 1.
// R14: control bit 4 written 1 soft-resets and sets flag; 0 clears flag.
// R15: control bit 5 set by low charge alarm, cleared by writing 0.
// R16: control bits 6 and 7 low voltage and lockout, cleared writing 0.
// R17: sixteen table entries pairing charge and voltage codes, with defaults.
// R18: voltage points use two byte registers each, low byte first.
// R19: charge points use one byte register each.
// R20: every register returns to default on power-on or soft reset.
// R21: host reads multi-byte values within one bus access.
// R22: mode bit 7 ignores writes and reads zero.
module gmcr_regs #(
	parameter int ENTRIES = gmcr_pkg::TAB_ENTRIES
) (
	input  wire logic                  I_SYS_CLK,
	input  wire logic                  I_RST_B,
	input  wire logic                  I_CLK_EN,
	input  wire logic                  I_REG_WR,
	input  wire logic                  I_REG_RD,
	input  wire logic [7:0]            I_REG_ADDR,
	input  wire logic [7:0]            I_REG_WDATA,
	input  wire logic                  I_ALARM_PIN_LEVEL,
	input  wire logic                  I_ALARM_COND,
	input  wire logic                  I_BATTERY_DETECT_INPUT,
	input  wire logic                  I_CHARGE_SOURCE_VOLTAGE,
	input  wire logic                  I_CHARGER_DISABLE_INT,
	input  wire logic                  I_LOW_CHARGE_EVT,
	input  wire logic                  I_LOW_VOLTAGE_EVT,
	input  wire logic                  I_UVLO_EVT,
	output logic [7:0]                 O_REG_RDATA,
	output logic                       O_REG_RVALID,
	output gmcr_pkg::gmcr_mode_t       O_MODE,
	output logic                       O_CHARGER_DISABLE_OUTPUT,
	output logic                       O_ALARM_PIN_O,
	output logic                       O_ALARM_PIN_OEN,
	output logic                       O_CONVERSION_COUNTER_CLEAR,
	output logic                       O_SOFT_RESET,
	output gmcr_pkg::gmcr_soc_tab_t    O_TABLE_CHARGE_POINTS,
	output gmcr_pkg::gmcr_ocv_tab_t    O_TABLE_VOLTAGE_POINTS
);

	gmcr_pkg::gmcr_mode_t    mode_q;
	gmcr_pkg::gmcr_mode_t    mode_d;
	gmcr_pkg::gmcr_ctrl_t    ctrl_q;
	gmcr_pkg::gmcr_ctrl_t    ctrl_d;
	gmcr_pkg::gmcr_soc_tab_t soc_q;
	gmcr_pkg::gmcr_soc_tab_t soc_d;
	gmcr_pkg::gmcr_ocv_tab_t ocv_q;
	gmcr_pkg::gmcr_ocv_tab_t ocv_d;
	logic                    cnt_clr_q;
	logic                    soft_rst_q;
	logic                    cd_q;
	logic                    alm_oen_q;
	logic [7:0]              rdata_q;
	logic                    rvalid_q;

	// address decode
	wire        wr_mode   = I_REG_WR && (I_REG_ADDR == gmcr_pkg::ADDR_MODE);
	wire        wr_ctrl   = I_REG_WR && (I_REG_ADDR == gmcr_pkg::ADDR_CTRL);
	wire        in_ocv    = (I_REG_ADDR >= gmcr_pkg::ADDR_OCV_BASE)
	                     && (I_REG_ADDR <= gmcr_pkg::ADDR_OCV_LAST);
	wire        in_soc    = (I_REG_ADDR >= gmcr_pkg::ADDR_SOC_BASE)
	                     && (I_REG_ADDR <= gmcr_pkg::ADDR_SOC_LAST);
	wire [7:0]  ocv_off   = I_REG_ADDR - gmcr_pkg::ADDR_OCV_BASE;
	wire [3:0]  ocv_idx   = ocv_off[4:1];
	wire        ocv_hi    = ocv_off[0];
	wire [3:0]  soc_idx   = I_REG_ADDR[3:0];
	wire        wr_ocv    = I_REG_WR && in_ocv;
	wire        wr_soc    = I_REG_WR && in_soc;

	// soft reset takes effect on the very edge of the write
	wire        soft_req  = wr_ctrl && I_REG_WDATA[gmcr_pkg::CTRL_POR]; // R14

	// operating mode next value
	always_comb begin
		mode_d = mode_q;
		mode_d.force_counter_state = 1'b0; // R6
		mode_d.force_voltage_state = 1'b0; // R7
		if (soft_req) begin
			mode_d = gmcr_pkg::MODE_RESET; // R20
		end else if (wr_mode) begin
			mode_d.voltage_only_select   = I_REG_WDATA[gmcr_pkg::MODE_VOLT_ONLY]; // R1
			mode_d.detect_pullup_enable  = I_REG_WDATA[gmcr_pkg::MODE_PULLUP]; // R2
			mode_d.charger_disable_force = I_REG_WDATA[gmcr_pkg::MODE_CD_FORCE]; // R3
			mode_d.alarm_enable          = I_REG_WDATA[gmcr_pkg::MODE_ALM_EN]; // R4
			mode_d.gauge_operate         = I_REG_WDATA[gmcr_pkg::MODE_OPERATE]; // R5
			mode_d.force_counter_state   = I_REG_WDATA[gmcr_pkg::MODE_FORCE_COUNTER_STATE]; // R6
			mode_d.force_voltage_state   = I_REG_WDATA[gmcr_pkg::MODE_FORCE_VOLTAGE_STATE]; // R7
		end
	end

	// control and status next value; a hardware set wins over a software clear
	always_comb begin
		ctrl_d = ctrl_q;
		ctrl_d.charge_source_voltage = I_CHARGE_SOURCE_VOLTAGE; // R11
		if (soft_req) begin
			ctrl_d = gmcr_pkg::CTRL_RESET; // R14 R20
		end else begin
			if (wr_ctrl) begin
				ctrl_d.alarm_pin_drive = I_REG_WDATA[gmcr_pkg::CTRL_ALM_PIN]; // R9
				ctrl_d.power_reset_flag = 1'b0; // R14
				if (!I_REG_WDATA[gmcr_pkg::CTRL_BAT_REM] && !I_BATTERY_DETECT_INPUT) begin
					ctrl_d.battery_removed_flag = 1'b0; // R12
				end
				if (!I_REG_WDATA[gmcr_pkg::CTRL_LOW_CHG]) begin
					ctrl_d.low_charge_flag = 1'b0; // R15
				end
				if (!I_REG_WDATA[gmcr_pkg::CTRL_LOW_VOLT]) begin
					ctrl_d.low_voltage_flag = 1'b0; // R16
				end
				if (!I_REG_WDATA[gmcr_pkg::CTRL_UVLO]) begin
					ctrl_d.undervoltage_lockout_flag = 1'b0; // R16
				end
			end
			if (I_BATTERY_DETECT_INPUT) begin
				ctrl_d.battery_removed_flag = 1'b1; // R12
			end
			if (I_LOW_CHARGE_EVT) begin
				ctrl_d.low_charge_flag = 1'b1; // R15
			end
			if (I_LOW_VOLTAGE_EVT) begin
				ctrl_d.low_voltage_flag = 1'b1; // R16
			end
			if (I_UVLO_EVT) begin
				ctrl_d.undervoltage_lockout_flag = 1'b1; // R16
			end
		end
	end

	// table entries, one per generate step
	for (genvar e = 0; e < ENTRIES; e++) begin : g_tab
		wire soc_hit = wr_soc && (soc_idx == 4'(e));
		wire ocv_hit = wr_ocv && (ocv_idx == 4'(e));
		assign soc_d[e] = soft_req ? gmcr_pkg::SOC_DEFAULT[e] // R17 R20
		                : soc_hit  ? I_REG_WDATA // R19
		                : soc_q[e];
		assign ocv_d[e][7:0]  = soft_req ? gmcr_pkg::OCV_DEFAULT[e][7:0] // R17 R20
		                      : (ocv_hit && !ocv_hi) ? I_REG_WDATA // R18
		                      : ocv_q[e][7:0];
		assign ocv_d[e][15:8] = soft_req ? gmcr_pkg::OCV_DEFAULT[e][15:8]
		                      : (ocv_hit && ocv_hi) ? I_REG_WDATA // R18
		                      : ocv_q[e][15:8];
	end

	// read-back selection
	wire [7:0] mode_rd = {1'b0, mode_q}; // R22
	wire [7:0] ctrl_rd = {ctrl_q.undervoltage_lockout_flag,
	                      ctrl_q.low_voltage_flag,
	                      ctrl_q.low_charge_flag,
	                      ctrl_q.power_reset_flag, // R13
	                      ctrl_q.battery_removed_flag,
	                      ctrl_q.charge_source_voltage, // R11
	                      1'b0,
	                      I_ALARM_PIN_LEVEL}; // R8
	wire [15:0] ocv_sel = ocv_q[ocv_idx];
	wire [7:0]  rd_mux  = (I_REG_ADDR == gmcr_pkg::ADDR_MODE) ? mode_rd
	                    : (I_REG_ADDR == gmcr_pkg::ADDR_CTRL) ? ctrl_rd
	                    : in_ocv ? (ocv_hi ? ocv_sel[15:8] : ocv_sel[7:0])
	                    : in_soc ? soc_q[soc_idx]
	                    : 8'h00;

	// pin drive: alarm is open drain, pulled low by force or active alarm
	wire alm_low = !ctrl_q.alarm_pin_drive // R9
	            || (mode_q.alarm_enable && I_ALARM_COND); // R4
	wire cd_d    = mode_q.charger_disable_force || I_CHARGER_DISABLE_INT; // R3

	always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			mode_q <= gmcr_pkg::MODE_RESET; // R1 R2 R4 R5
			ctrl_q <= gmcr_pkg::CTRL_RESET; // R13
		end else if (I_CLK_EN) begin
			mode_q <= mode_d;
			ctrl_q <= ctrl_d;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			soc_q <= gmcr_pkg::SOC_DEFAULT; // R17
			ocv_q <= gmcr_pkg::OCV_DEFAULT; // R17
		end else if (I_CLK_EN) begin
			soc_q <= soc_d;
			ocv_q <= ocv_d;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			cnt_clr_q  <= 1'b0;
			soft_rst_q <= 1'b0;
			cd_q       <= 1'b0;
			alm_oen_q  <= 1'b1;
		end else if (I_CLK_EN) begin
			cnt_clr_q  <= wr_ctrl && I_REG_WDATA[gmcr_pkg::CTRL_CNT_CLR]; // R10
			soft_rst_q <= soft_req; // R14
			cd_q       <= cd_d;
			alm_oen_q  <= !alm_low;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
		end else if (I_CLK_EN) begin
			rvalid_q <= I_REG_RD;
			if (I_REG_RD) begin
				rdata_q <= rd_mux;
			end
		end
	end

	assign O_REG_RDATA                = rdata_q;
	assign O_REG_RVALID               = rvalid_q;
	assign O_MODE                     = mode_q;
	assign O_CHARGER_DISABLE_OUTPUT   = cd_q;
	assign O_ALARM_PIN_O              = 1'b0;
	assign O_ALARM_PIN_OEN            = alm_oen_q;
	assign O_CONVERSION_COUNTER_CLEAR = cnt_clr_q;
	assign O_SOFT_RESET               = soft_rst_q;
	assign O_TABLE_CHARGE_POINTS      = soc_q;
	assign O_TABLE_VOLTAGE_POINTS     = ocv_q;

endmodule

`default_nettype wire

// *** testbench/gmcr_regs_assertions.sv ***
// Purpose: port assertions for the gauge mode and control registers
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound to every register bank instance
`timescale 1ns/1ps
`default_nettype none
module gmcr_regs_assertions (
	input wire logic                 I_SYS_CLK,
	input wire logic                 I_RST_B,
	input wire logic                 I_CLK_EN,
	input wire logic                 I_REG_WR,
	input wire logic                 I_REG_RD,
	input wire logic [7:0]           I_REG_ADDR,
	input wire logic [7:0]           I_REG_WDATA,
	input wire logic                 I_ALARM_PIN_LEVEL,
	input wire logic                 I_ALARM_COND,
	input wire logic [7:0]           O_REG_RDATA,
	input wire gmcr_pkg::gmcr_mode_t O_MODE,
	input wire logic                 O_CHARGER_DISABLE_OUTPUT,
	input wire logic                 O_ALARM_PIN_OEN,
	input wire logic                 O_CONVERSION_COUNTER_CLEAR,
	input wire logic                 O_SOFT_RESET
);
	logic wr_mode, wr_ctrl, rd_mode, rd_ctrl;
	assign wr_mode = I_CLK_EN & I_REG_WR & (I_REG_ADDR == gmcr_pkg::ADDR_MODE);
	assign wr_ctrl = I_CLK_EN & I_REG_WR & (I_REG_ADDR == gmcr_pkg::ADDR_CTRL);
	assign rd_mode = I_CLK_EN & I_REG_RD & (I_REG_ADDR == gmcr_pkg::ADDR_MODE);
	assign rd_ctrl = I_CLK_EN & I_REG_RD & (I_REG_ADDR == gmcr_pkg::ADDR_CTRL);
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_RST_B);
	AST_ALM_LEVEL: assert property (rd_ctrl |=> O_REG_RDATA[0] == $past(I_ALARM_PIN_LEVEL))
		else $error("alarm level readback wrong");
	AST_MODE_B7: assert property (rd_mode |=> !O_REG_RDATA[7])
		else $error("mode bit 7 reads one");
	AST_FORCE_COUNTER_STATE: assert property (wr_mode && I_REG_WDATA[5] |=> O_MODE.force_counter_state ##1
		(!O_MODE.force_counter_state || $past(wr_mode))) else $error("counter force pulse wrong");
	AST_FORCE_VOLTAGE_STATE: assert property (wr_mode && I_REG_WDATA[6] |=> O_MODE.force_voltage_state)
		else $error("voltage force pulse missing");
	AST_CD_FORCE: assert property (O_MODE.charger_disable_force && !wr_ctrl |=> O_CHARGER_DISABLE_OUTPUT)
		else $error("charger disable not forced");
	AST_ALM_EN: assert property (O_MODE.alarm_enable && I_ALARM_COND && !wr_ctrl |=> !O_ALARM_PIN_OEN)
		else $error("alarm pin not pulled low");
	AST_CNT_CLR: assert property (wr_ctrl && I_REG_WDATA[1] && !I_REG_WDATA[4] |=> O_CONVERSION_COUNTER_CLEAR)
		else $error("counter clear pulse missing");
	AST_SOFT_RST: assert property (wr_ctrl && I_REG_WDATA[4] |=> O_SOFT_RESET && O_MODE == gmcr_pkg::MODE_RESET)
		else $error("soft reset did not restore mode");
	cover property (wr_ctrl && I_REG_WDATA[4]);
	cover property (rd_ctrl);
	cover property (O_MODE.alarm_enable && I_ALARM_COND);
endmodule
bind gmcr_regs gmcr_regs_assertions i_gmcr_regs_assertions (.I_SYS_CLK, .I_RST_B, .I_CLK_EN, .I_REG_WR,
	.I_REG_RD, .I_REG_ADDR, .I_REG_WDATA, .I_ALARM_PIN_LEVEL, .I_ALARM_COND, .O_REG_RDATA, .O_MODE,
	.O_CHARGER_DISABLE_OUTPUT, .O_ALARM_PIN_OEN, .O_CONVERSION_COUNTER_CLEAR, .O_SOFT_RESET);
`default_nettype wire

// *** testbench/gmcr_host.sv ***
// Purpose: host model issuing byte register accesses
// Assumes: strobes launched just after a rising edge
// Notes:   idle address and data show the inverted first address of the last access and the inverted last written data
`timescale 1ns/1ps
`default_nettype none
module gmcr_host (
	input  wire logic       i_clk,
	input  wire logic [7:0] i_rdata,
	input  wire logic       i_rvalid,
	output var  logic       o_wr,
	output var  logic       o_rd,
	output var  logic [7:0] o_addr,
	output var  logic [7:0] o_wdata
);
	initial begin
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = 8'hFF;
		o_wdata = 8'h00;
	end
	task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_wr <= 1'b1;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask
	task automatic rd_b(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk);
		o_rd <= 1'b1;
		o_addr <= a;
		@(posedge i_clk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		@(posedge i_clk);
		d = i_rvalid ? i_rdata : 8'hXX;
	endtask
	// low then high byte in one burst
	task automatic rd_w(input logic [7:0] a, output logic [15:0] d);
		@(posedge i_clk);
		o_rd <= 1'b1;
		o_addr <= a;
		@(posedge i_clk);
		o_addr <= a + 8'h01;
		@(posedge i_clk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		d[7:0] = i_rdata;
		@(posedge i_clk);
		d[15:8] = i_rdata;
	endtask
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// Purpose: self-checking bench for the gauge register bank
// Assumes: clock enable high except in the freeze case
// Notes:   reset rows rerun after a soft reset
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clk, rst_b, alm_lvl, cond, det, src, cd_int, lo_chg, lo_v, uvlo;
	logic        wr, rd, rvalid, cd, alm_o, oen, en;
	logic [7:0]  addr, wdata, rdata, v;
	logic [15:0] w;
	gmcr_pkg::gmcr_mode_t    mode;
	gmcr_pkg::gmcr_soc_tab_t soc_tab;
	gmcr_pkg::gmcr_ocv_tab_t ocv_tab;
	int          n_errors, checks_done, cyc;
	logic [15:0] rows [11] = '{16'h000B, 16'h0111, 16'h3070, 16'h3117, 16'h4EA9, 16'h4F1D,
		16'h5000, 16'h5528, 16'h5FC8, 16'h0200, 16'h6000};
	gmcr_regs i_gmcr_regs (.I_SYS_CLK(clk), .I_RST_B(rst_b), .I_CLK_EN(en), .I_REG_WR(wr), .I_REG_RD(rd),
		.I_REG_ADDR(addr), .I_REG_WDATA(wdata), .I_ALARM_PIN_LEVEL(alm_lvl), .I_ALARM_COND(cond),
		.I_BATTERY_DETECT_INPUT(det), .I_CHARGE_SOURCE_VOLTAGE(src), .I_CHARGER_DISABLE_INT(cd_int),
		.I_LOW_CHARGE_EVT(lo_chg), .I_LOW_VOLTAGE_EVT(lo_v), .I_UVLO_EVT(uvlo), .O_REG_RDATA(rdata),
		.O_REG_RVALID(rvalid), .O_MODE(mode), .O_CHARGER_DISABLE_OUTPUT(cd), .O_ALARM_PIN_O(alm_o),
		.O_ALARM_PIN_OEN(oen), .O_CONVERSION_COUNTER_CLEAR(), .O_SOFT_RESET(),
		.O_TABLE_CHARGE_POINTS(soc_tab), .O_TABLE_VOLTAGE_POINTS(ocv_tab));
	gmcr_host i_gmcr_host (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_wr(wr), .o_rd(rd),
		.o_addr(addr), .o_wdata(wdata));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e) begin
			n_errors++;
			$display("mismatch %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic run_rows();
		for (int i = 0; i < 11; i++) begin
			i_gmcr_host.rd_b(rows[i][15:8], v);
			chk($sformatf("reg%h", rows[i][15:8]), {8'h00, v}, {8'h00, rows[i][7:0]});
		end
	endtask
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
		i_gmcr_host.wr_b(a, d);
		i_gmcr_host.rd_b(a, v);
		chk($sformatf("wr%h", d), {8'h00, v}, {8'h00, e});
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			end_sim();
		end
	end
	initial begin
		{rst_b, cond, det, src, cd_int, lo_chg, lo_v, uvlo} = 8'h00;
		alm_lvl = 1'b1;
		en = 1'b1;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		run_rows();
		chk("alm_o", {15'h0000, alm_o}, 16'h0000);
		wr_rd(8'h00, 8'hF4, 8'h14);
		chk("cd", {15'h0000, cd}, 16'h0001);
		i_gmcr_host.wr_b(8'h00, 8'h08);
		cond <= 1'b1;
		repeat (2) @(posedge clk);
		chk("cd", {15'h0000, cd}, 16'h0000);
		chk("oen", {15'h0000, oen}, 16'h0000);
		i_gmcr_host.wr_b(8'h00, 8'h00);
		cd_int <= 1'b1;
		repeat (2) @(posedge clk);
		chk("oen", {15'h0000, oen}, 16'h0001);
		chk("cd", {15'h0000, cd}, 16'h0001);
		{cond, cd_int, alm_lvl} <= 3'h0;
		wr_rd(8'h01, 8'h00, 8'h00);
		chk("oen", {15'h0000, oen}, 16'h0000);
		i_gmcr_host.wr_b(8'h01, 8'h01);
		@(posedge clk);
		{det, src, lo_chg, lo_v, uvlo} <= 5'h1F;
		@(posedge clk);
		{lo_chg, lo_v, uvlo} <= 3'h0;
		repeat (2) @(posedge clk);
		chk("oen", {15'h0000, oen}, 16'h0001);
		wr_rd(8'h01, 8'hE9, 8'hEC);
		wr_rd(8'h01, 8'h03, 8'h0C);
		{det, src} <= 2'h0;
		wr_rd(8'h01, 8'h01, 8'h00);
		i_gmcr_host.wr_b(8'h30, 8'h34);
		i_gmcr_host.wr_b(8'h31, 8'h12);
		i_gmcr_host.wr_b(8'h5F, 8'h55);
		@(negedge clk);
		chk("ocv0", ocv_tab[0], 16'h1234);
		chk("soc15", {8'h00, soc_tab[15]}, 16'h0055);
		i_gmcr_host.rd_w(8'h30, w);
		chk("ocv0 rd", w, 16'h1234);
		alm_lvl <= 1'b1;
		i_gmcr_host.wr_b(8'h01, 8'h10);
		run_rows();
		i_gmcr_host.rd_w(8'h30, w);
		chk("ocv0 rst", w, 16'h1770);
		en <= 1'b0;
		i_gmcr_host.wr_b(8'h00, 8'h1F);
		en <= 1'b1;
		i_gmcr_host.rd_b(8'h00, v);
		chk("mode frozen", {8'h00, v}, 16'h000B);
		end_sim();
	end
endmodule
`default_nettype wire
